/* File: logic/css_core.sv */
// cpu programmer state, alu and program sequencing core
`default_nettype none
module css_core
	import css_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire css_op_s op,
	input wire logic op_valid,
	output logic op_ready,
	output logic [11:0] pc,
	output logic [11:0] rom_addr,
	output logic rom_rd,
	input wire logic [9:0] rom_data,
	input wire logic [7:0] irq_req,
	input wire logic [7:0] irq_en,
	output logic [7:0] irq_ack,
	output logic [7:0] port_d,
	input wire logic [7:0] port_d_in,
	input wire css_bus_s bus,
	output logic [15:0] rd_data
);
	logic rst_s1_r;
	logic rst_n;
	logic [3:0] acc_r, acc_nxt, b_r, b_nxt;
	logic [7:0] e_r, e_nxt;
	logic cy_r, cy_nxt, skip_r, skip_nxt;
	logic [2:0] d_r, d_nxt, sp_r, sp_nxt, x_r, x_nxt, prio;
	logic z_r, z_nxt;
	logic [3:0] y_r, y_nxt;
	logic [11:0] pc_r, pc_nxt, ret_addr, rom_addr_r, rom_addr_nxt;
	logic [11:0] stk [CSS_STK_N];
	logic [3:0] ram [CSS_RAM_N];
	logic [3:0] mem, ram_wd, bmask;
	logic ram_we, push, pop, save_we, restore;
	logic [4:0] sum;
	css_save_s save_r;
	css_st_e st_r, st_nxt;
	logic gate_r, gate_nxt, ei_pend_r, ei_pend_nxt;
	logic [7:0] port_d_r, port_d_nxt, ack_r, ack_nxt, pend;
	logic ready_r, rom_rd_r;
	logic [15:0] rd_data_r;
	logic exec, take_irq;

	// fixed priority: lowest index wins, so external zero is served first
	function automatic logic [2:0] css_prio(input logic [7:0] p);
		logic [2:0] v;
		v = 3'h0;
		for (int i = CSS_IRQ_N - 1; i >= 0; i--)
		begin
			if (p[i])
				v = 3'(i);
		end
		return v;
	endfunction

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_s1_r <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_n <= rst_s1_r;
		end
	end

	assign pend = irq_req & irq_en;
	assign prio = css_prio(pend);
	// interrupts only slot in between ops, so an issued op is never lost
	assign take_irq = gate_r && (|pend) && st_r == ST_RUN && !op_valid;
	assign exec = op_valid && st_r == ST_RUN;
	assign mem = ram[{z_r, x_r, y_r}];
	assign bmask = 4'h1 << op.bitsel;
	assign ret_addr = pc_r + (op.two_word ? 12'h002 : 12'h001);

	// next-state decode of one op or an interrupt entry
	always_comb
	begin
		acc_nxt = acc_r;
		b_nxt = b_r;
		e_nxt = e_r;
		cy_nxt = cy_r;
		skip_nxt = skip_r;
		d_nxt = d_r;
		z_nxt = z_r;
		x_nxt = x_r;
		y_nxt = y_r;
		pc_nxt = pc_r;
		sp_nxt = sp_r;
		push = 1'b0;
		pop = 1'b0;
		ram_we = 1'b0;
		ram_wd = mem;
		port_d_nxt = port_d_r;
		gate_nxt = gate_r;
		ei_pend_nxt = ei_pend_r;
		save_we = 1'b0;
		restore = 1'b0;
		st_nxt = st_r;
		rom_addr_nxt = rom_addr_r;
		ack_nxt = 8'h00;
		sum = 5'h00;
		if (take_irq)
		begin
			push = 1'b1;
			save_we = 1'b1;
			// pending skip rides in the save stage, so the handler's first op still runs
			skip_nxt = 1'b0;
			pc_nxt = CSS_VEC_BASE | {8'h00, prio, 1'b0};
			gate_nxt = 1'b0;
			ack_nxt = 8'h01 << prio;
		end
		else if (st_r == ST_TBL)
		begin
			// second half of a lookup: data in, pc back from the stack
			acc_nxt = rom_data[3:0];
			b_nxt = rom_data[7:4];
			pop = 1'b1;
			pc_nxt = stk[sp_r];
			st_nxt = ST_RUN;
		end
		else if (exec && skip_r)
		begin
			// skipped op is dropped but its words are still passed over
			skip_nxt = 1'b0;
			pc_nxt = ret_addr;
		end
		else if (exec)
		begin
			pc_nxt = ret_addr;
			if (ei_pend_r && op.code != OP_EI)
			begin
				gate_nxt = 1'b1;
				ei_pend_nxt = 1'b0;
			end
			case (op.code)
				OP_ADD_IMM:
					acc_nxt = acc_r + op.imm;
				OP_ADD_MEM:
					acc_nxt = acc_r + mem;
				OP_ADD_CY:
				begin
					sum = {1'b0, acc_r} + {1'b0, mem} + {4'h0, cy_r};
					acc_nxt = sum[3:0];
					cy_nxt = sum[4];
				end
				OP_CMP_IMM:
					skip_nxt = (acc_r == op.imm);
				OP_AND_MEM:
					acc_nxt = acc_r & mem;
				OP_OR_MEM:
					acc_nxt = acc_r | mem;
				OP_ROT_R:
				begin
					acc_nxt = {cy_r, acc_r[3:1]};
					cy_nxt = acc_r[0];
				end
				OP_SET_CY:
					cy_nxt = 1'b1;
				OP_CLR_CY:
					cy_nxt = 1'b0;
				OP_LOAD_IMM:
					acc_nxt = op.imm;
				OP_E_FROM_BA:
					e_nxt = {b_r, acc_r};
				OP_BA_FROM_E:
				begin
					b_nxt = e_r[7:4];
					acc_nxt = e_r[3:0];
				end
				OP_LOAD_D:
					d_nxt = op.imm[2:0];
				OP_LOAD_DP:
				begin
					z_nxt = op.target[7];
					x_nxt = op.target[6:4];
					y_nxt = op.target[3:0];
				end
				OP_MBIT_SET:
				begin
					ram_we = 1'b1;
					ram_wd = mem | bmask;
				end
				OP_MBIT_CLR:
				begin
					ram_we = 1'b1;
					ram_wd = mem & ~bmask;
				end
				OP_MBIT_SKIP:
					skip_nxt = ((mem & bmask) == 4'h0);
				OP_PBIT_SET:
					port_d_nxt[y_r[2:0]] = 1'b1;
				OP_PBIT_CLR:
					port_d_nxt[y_r[2:0]] = 1'b0;
				OP_PBIT_SKIP:
					skip_nxt = !port_d_in[y_r[2:0]];
				OP_JUMP:
					pc_nxt = op.target;
				OP_CALL:
				begin
					push = 1'b1;
					pc_nxt = op.target;
				end
				OP_P2_CALL:
				begin
					push = 1'b1;
					pc_nxt = {CSS_PAGE2, op.target[6:0]};
				end
				OP_JUMP_ACC:
					pc_nxt = {op.target[11:7], d_r, acc_r};
				OP_P2_CALL_ACC:
				begin
					push = 1'b1;
					pc_nxt = {CSS_PAGE2, d_r, acc_r};
				end
				OP_TBL:
				begin
					// holds one stack level while the rom word is fetched
					push = 1'b1;
					rom_addr_nxt = {op.target[11:7], d_r, acc_r};
					st_nxt = ST_TBL;
				end
				OP_RET:
				begin
					pop = 1'b1;
					pc_nxt = stk[sp_r];
				end
				OP_RET_IRQ:
				begin
					pop = 1'b1;
					restore = 1'b1;
					pc_nxt = stk[sp_r];
				end
				OP_SP_TO_ACC:
					acc_nxt = {1'b0, sp_r};
				OP_EI:
					ei_pend_nxt = 1'b1;
				OP_DI:
				begin
					gate_nxt = 1'b0;
					ei_pend_nxt = 1'b0;
				end
				default:
					acc_nxt = acc_r;
			endcase
			if (restore)
			begin
				z_nxt = save_r.z;
				x_nxt = save_r.x;
				y_nxt = save_r.y;
				cy_nxt = save_r.cy;
				skip_nxt = save_r.skip;
				acc_nxt = save_r.acc;
				b_nxt = save_r.b;
			end
		end
		// bus write to gate is ignored in an entry cycle: hardware clear wins
		if (bus.wr && bus.addr == CSS_REG_CTRL && !take_irq)
			gate_nxt = bus.wdata[CSS_CTRL_GATE];
		if (push)
			sp_nxt = sp_r + 3'h1;
		else if (pop)
			sp_nxt = sp_r - 3'h1;
	end

	// alu result registers and carry
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc_r <= 4'h0;
			b_r <= 4'h0;
			e_r <= 8'h00;
			cy_r <= 1'b0;
			skip_r <= 1'b0;
		end
		else
		begin
			acc_r <= acc_nxt;
			b_r <= b_nxt;
			e_r <= e_nxt;
			cy_r <= cy_nxt;
			skip_r <= skip_nxt;
		end
	end

	// pointers: d and the ram data pointer
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			d_r <= 3'h0;
			z_r <= 1'b0;
			x_r <= 3'h0;
			y_r <= 4'h0;
		end
		else
		begin
			d_r <= d_nxt;
			z_r <= z_nxt;
			x_r <= x_nxt;
			y_r <= y_nxt;
		end
	end

	// sequencing: pc, stack pointer, lookup state
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pc_r <= CSS_PC_RST;
			sp_r <= CSS_SP_RST;
			st_r <= ST_RUN;
			rom_addr_r <= CSS_PC_RST;
			rom_rd_r <= 1'b0;
			ready_r <= 1'b0;
		end
		else
		begin
			pc_r <= pc_nxt;
			sp_r <= sp_nxt;
			st_r <= st_nxt;
			rom_addr_r <= rom_addr_nxt;
			rom_rd_r <= (st_nxt == ST_TBL) && (st_r == ST_RUN);
			ready_r <= (st_nxt == ST_RUN);
		end
	end

	// stack entries; a ninth push lands on entry zero and destroys it
	always_ff @(posedge clk)
	begin
		if (push)
			stk[sp_nxt] <= take_irq ? pc_r : ret_addr;
	end

	// one-stage save, written on interrupt entry only
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			save_r <= '0;
		else if (save_we)
			save_r <= '{z_r, x_r, y_r, cy_r, skip_r, acc_r, b_r};
	end

	// data ram, no reset: contents are undefined at power up
	always_ff @(posedge clk)
	begin
		if (ram_we)
			ram[{z_r, x_r, y_r}] <= ram_wd;
	end

	// interrupt gate, delayed enable, acknowledges and port d latch
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gate_r <= 1'b0;
			ei_pend_r <= 1'b0;
			ack_r <= 8'h00;
			port_d_r <= 8'h00;
		end
		else
		begin
			gate_r <= gate_nxt;
			ei_pend_r <= ei_pend_nxt;
			ack_r <= ack_nxt;
			port_d_r <= port_d_nxt;
		end
	end

	// register read port, data valid the cycle after the strobe
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rd_data_r <= 16'h0000;
		else if (bus.rd)
		begin
			case (bus.addr)
				CSS_REG_CTRL:
					rd_data_r <= {15'h0000, gate_r};
				CSS_REG_STAT:
					rd_data_r <= {8'h00, sp_r, ei_pend_r, st_r, skip_r, cy_r, gate_r};
				CSS_REG_PAIR:
					rd_data_r <= {e_r, b_r, acc_r};
				CSS_REG_PC:
					rd_data_r <= {4'h0, pc_r};
				default:
					rd_data_r <= 16'h0000;
			endcase
		end
		else
			rd_data_r <= 16'h0000;
	end

	assign op_ready = ready_r;
	assign pc = pc_r;
	assign rom_addr = rom_addr_r;
	assign rom_rd = rom_rd_r;
	assign irq_ack = ack_r;
	assign port_d = port_d_r;
	assign rd_data = rd_data_r;

	chk_sp_reset_value: assert property (@(posedge clk) $rose(rst_n) |-> sp_r == 3'h7)
		else $error("stack pointer not seven after reset");
	chk_rotate_carry: assert property (@(posedge clk) disable iff (!rst_n)
		exec && !skip_r && !take_irq && op.code == OP_ROT_R |=> cy_r == $past(acc_r[0]))
		else $error("rotate did not move bit zero into carry");
	chk_carry_force: assert property (@(posedge clk) disable iff (!rst_n)
		exec && !skip_r && op.code == OP_SET_CY |=> cy_r)
		else $error("set carry did not set carry");
	chk_carry_clear: assert property (@(posedge clk) disable iff (!rst_n)
		exec && !skip_r && op.code == OP_CLR_CY |=> !cy_r)
		else $error("clear carry did not clear carry");
	chk_irq_skip_saved: assert property (@(posedge clk) disable iff (!rst_n)
		take_irq |=> !skip_r && save_r.skip == $past(skip_r))
		else $error("skip flag not moved into save stage on entry");
	chk_add_keeps_cy: assert property (@(posedge clk) disable iff (!rst_n)
		exec && !skip_r && (op.code == OP_ADD_IMM || op.code == OP_ADD_MEM) |=> $stable(cy_r))
		else $error("plain add changed carry");
	chk_irq_entry: assert property (@(posedge clk) disable iff (!rst_n)
		take_irq |=> !gate_r && irq_ack == (8'h01 << $past(prio)) ##1 irq_ack == 8'h00)
		else $error("interrupt entry gate or acknowledge wrong");
	chk_irq_vector: assert property (@(posedge clk) disable iff (!rst_n)
		take_irq |=> pc_r[11:7] == 5'h01 && pc_r[0] == 1'b0)
		else $error("interrupt vector outside page one");
	chk_irq_needs_gate: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(|ack_r) |-> $past(gate_r) && ($past(pend) & ack_r) != 8'h00)
		else $error("interrupt taken without gate or enabled request");
	chk_sp_push_wrap: assert property (@(posedge clk) disable iff (!rst_n)
		push && sp_r == 3'h7 |=> sp_r == 3'h0)
		else $error("stack pointer did not wrap to zero");
	chk_save_restore: assert property (@(posedge clk) disable iff (!rst_n)
		take_irq ##1 (exec && !skip_r && op.code == OP_RET_IRQ) |=> acc_r == $past(acc_r, 2))
		else $error("return from interrupt lost accumulator");
	chk_table_data: assert property (@(posedge clk) disable iff (!rst_n)
		st_r == ST_TBL |=> acc_r == $past(rom_data[3:0]) && b_r == $past(rom_data[7:4]) && op_ready)
		else $error("lookup data or completion wrong");
endmodule
`default_nettype wire

/* File: logic/css_pkg.sv */
// constants, types and rule summary for the cpu state and sequencing core
// Function
// - alu adds, compares, ands, ors, manipulates bits
// - carry set by add-with-carry, not plain add
// - rotate right copies acc bit0 to carry
// - set and clear carry ops force carry
// - e pairs b high and acc low
// - d and acc form in-page address
// - eight-entry stack saves pc on calls
// - stack pointer wraps seven to zero
// - stack pointer readable into accumulator
// - pointer seven after reset, first call zero
// - save stage holds pointer, flags, acc, b
// - calls and lookups leave save stage alone
// - skip flag drives skips, saved on interrupt
// - pc advances by length or loads target
// - pc page from bit7 up, offset carries into next page
// - z x y select ram, y port bit
// - program words ten bits, pages 128 words
// - interrupt loads vector in page one
// - one-word call into page two anywhere
// - lookup returns low eight rom bits
// - ram four bits, any bit manipulable
// - interrupt needs request, enable and gate
// - entry clears gate, pulses ack of serviced request
// - fixed priority, external zero highest
`default_nettype none
package css_pkg;
	localparam int unsigned CSS_PC_W = 12;
	localparam int unsigned CSS_OFS_W = 7;
	localparam int unsigned CSS_PAGE_W = CSS_PC_W - CSS_OFS_W;
	localparam int unsigned CSS_ROM_W = 10;
	localparam int unsigned CSS_STK_N = 8;
	localparam int unsigned CSS_IRQ_N = 8;
	localparam int unsigned CSS_RAM_N = 256;
	localparam logic [2:0] CSS_SP_RST = 3'h7;
	localparam logic [4:0] CSS_PAGE2 = 5'h02;
	localparam logic [11:0] CSS_VEC_BASE = 12'h080;
	localparam logic [11:0] CSS_PC_RST = 12'h000;
	// register bus map, word offsets
	localparam logic [3:0] CSS_REG_CTRL = 4'h0;
	localparam logic [3:0] CSS_REG_STAT = 4'h4;
	localparam logic [3:0] CSS_REG_PAIR = 4'h8;
	localparam logic [3:0] CSS_REG_PC = 4'hC;
	localparam int unsigned CSS_CTRL_GATE = 0;

	typedef enum logic [4:0] {
		OP_NOP = 5'h00, OP_ADD_IMM = 5'h01, OP_ADD_MEM = 5'h02, OP_ADD_CY = 5'h03,
		OP_CMP_IMM = 5'h04, OP_AND_MEM = 5'h05, OP_OR_MEM = 5'h06, OP_ROT_R = 5'h07,
		OP_SET_CY = 5'h08, OP_CLR_CY = 5'h09, OP_LOAD_IMM = 5'h0A, OP_E_FROM_BA = 5'h0B,
		OP_BA_FROM_E = 5'h0C, OP_LOAD_D = 5'h0D, OP_LOAD_DP = 5'h0E, OP_MBIT_SET = 5'h0F,
		OP_MBIT_CLR = 5'h10, OP_MBIT_SKIP = 5'h11, OP_PBIT_SET = 5'h12, OP_PBIT_CLR = 5'h13,
		OP_PBIT_SKIP = 5'h14, OP_JUMP = 5'h15, OP_CALL = 5'h16, OP_P2_CALL = 5'h17,
		OP_JUMP_ACC = 5'h18, OP_P2_CALL_ACC = 5'h19, OP_TBL = 5'h1A, OP_RET = 5'h1B,
		OP_RET_IRQ = 5'h1C, OP_SP_TO_ACC = 5'h1D, OP_EI = 5'h1E, OP_DI = 5'h1F
	} css_op_e;

	typedef enum logic [0:0] {
		ST_RUN = 1'b0,
		ST_TBL = 1'b1
	} css_st_e;

	typedef struct packed {
		css_op_e code;
		logic two_word;
		logic [3:0] imm;
		logic [1:0] bitsel;
		logic [11:0] target;
	} css_op_s;

	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} css_bus_s;

	typedef struct packed {
		logic z;
		logic [2:0] x;
		logic [3:0] y;
		logic cy;
		logic skip;
		logic [3:0] acc;
		logic [3:0] b;
	} css_save_s;
endpackage
`default_nettype wire

/* File: tb/css_core_tb.sv */
// self-checking bench for the cpu state and sequencing core
`default_nettype none
`define CMP(g, e, m) if (((g) & (m)) !== ((e) & (m))) begin errors++; $display("mismatch t=%0t got %h exp %h", $time, g, e); end
module css_core_tb;
	import css_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_b, op_valid, op_ready, rom_rd;
	logic rd_q = 1'b0;
	logic [7:0] pd_q = 8'h00;
	logic [15:0] got;
	css_op_s op;
	css_bus_s bus;
	logic [11:0] pc, rom_addr;
	logic [9:0] rom_data;
	logic [7:0] irq_req, irq_en, irq_ack, port_d, port_d_in;
	logic [15:0] rd_data;
	logic [31:0] exp_q[$];
	logic [31:0] note;
	logic [3:0] a, b;
	int errors, num_checks, n;
	int unsigned seed;

	css_core css_core_i (.clk(clk), .rst_b(rst_b), .op(op), .op_valid(op_valid), .op_ready(op_ready), .pc(pc),
		.rom_addr(rom_addr), .rom_rd(rom_rd), .rom_data(rom_data), .irq_req(irq_req), .irq_en(irq_en),
		.irq_ack(irq_ack), .port_d(port_d), .port_d_in(port_d_in), .bus(bus), .rd_data(rd_data));
	css_rom_model css_rom_model_i (.rom_addr(rom_addr), .rom_rd(rom_rd), .rom_data(rom_data));

	// 200 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// watcher: oldest note against each read answer, acknowledge pulse or port d change
	// quiet during reset, while the core's outputs may still be unknown
	always @(posedge clk)
	begin
		rd_q <= bus.rd;
		pd_q <= port_d;
		if (rst_b && (rd_q || irq_ack !== 8'h00 || port_d !== pd_q))
		begin
			num_checks++;
			note = exp_q.size() > 0 ? exp_q.pop_front() : 32'hFFFF_5A5A;
			got = rd_q ? rd_data : (irq_ack !== 8'h00 ? {8'h00, irq_ack} : {8'h00, port_d});
			`CMP(got, note[15:0], note[31:16])
		end
	end

	// one gap cycle after each op keeps the lookup's busy cycle clear
	task automatic do_op(input css_op_e c, input logic [3:0] i = 4'h0, input logic [11:0] t = 12'h000,
		input logic [1:0] s = 2'h0, input logic tw = 1'b0);
		@(posedge clk);
		op <= '{code: c, two_word: tw, imm: i, bitsel: s, target: t};
		op_valid <= 1'b1;
		@(posedge clk);
		op_valid <= 1'b0;
	endtask

	task automatic bus_acc(input logic [3:0] ad, input logic w, input logic [15:0] v, input logic [15:0] m);
		if (!w)
			exp_q.push_back({m, v});
		@(posedge clk);
		bus <= '{addr: ad, wdata: v, wr: w, rd: !w};
		@(posedge clk);
		bus.wr <= 1'b0;
		bus.rd <= 1'b0;
	endtask

	task automatic end_of_test();
		if (exp_q.size() != 0)
			errors++;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// hang guard, far beyond the few hundred cycles the tests need
	initial
	begin
		repeat (4000) @(posedge clk);
		errors++;
		$display("mismatch t=%0t watchdog expired", $time);
		end_of_test();
	end

	initial
	begin
		rst_b = 1'b0;
		op_valid = 1'b0;
		op = '0;
		bus = '0;
		irq_req = 8'h00;
		irq_en = 8'h00;
		port_d_in = 8'h00;
		seed = $urandom(32'h3540);
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		for (n = 0; n < 10 && op_ready !== 1'b1; n++)
			@(posedge clk);
		if (op_ready !== 1'b1)
		begin
			errors++;
			$display("mismatch t=%0t core never ready after reset", $time);
		end
		// reset state and an unmapped read
		bus_acc(CSS_REG_STAT, 1'b0, 16'h00E0, 16'h00FF);
		bus_acc(CSS_REG_PC, 1'b0, {4'h0, CSS_PC_RST}, 16'hFFFF);
		bus_acc(4'h2, 1'b0, 16'h0000, 16'hFFFF);
		$display("test reset done");
		// ram word to all ones by single bits, then carry behaviour
		do_op(OP_LOAD_DP, 4'h0, 12'h035);
		for (n = 0; n < 4; n++)
			do_op(OP_MBIT_SET, 4'h0, 12'h000, 2'(n));
		do_op(OP_LOAD_IMM, 4'h1);
		do_op(OP_CLR_CY);
		do_op(OP_ADD_CY);
		bus_acc(CSS_REG_PAIR, 1'b0, 16'h0000, 16'h000F);
		bus_acc(CSS_REG_STAT, 1'b0, 16'h0002, 16'h0002);
		do_op(OP_ADD_IMM, 4'h3);
		bus_acc(CSS_REG_PAIR, 1'b0, 16'h0003, 16'h000F);
		bus_acc(CSS_REG_STAT, 1'b0, 16'h0002, 16'h0002);
		do_op(OP_LOAD_IMM, 4'h2);
		do_op(OP_ROT_R);
		bus_acc(CSS_REG_PAIR, 1'b0, 16'h0009, 16'h000F);
		bus_acc(CSS_REG_STAT, 1'b0, 16'h0000, 16'h0002);
		do_op(OP_SET_CY);
		bus_acc(CSS_REG_STAT, 1'b0, 16'h0002, 16'h0002);
		do_op(OP_CLR_CY);
		bus_acc(CSS_REG_STAT, 1'b0, 16'h0000, 16'h0002);
		$display("test carry done");
		// random alu operands; ram word holds all ones
		repeat (4)
		begin
			a = 4'($urandom);
			b = 4'($urandom);
			do_op(OP_LOAD_IMM, a);
			do_op(OP_ADD_IMM, b);
			do_op(OP_AND_MEM);
			bus_acc(CSS_REG_PAIR, 1'b0, 16'(4'(a + b)), 16'h000F);
			do_op(OP_CMP_IMM, 4'(a + b) ^ 4'h1);
			do_op(OP_LOAD_IMM, ~a);
			do_op(OP_CMP_IMM, ~a);
			do_op(OP_LOAD_IMM, a);
			bus_acc(CSS_REG_PAIR, 1'b0, 16'(~a), 16'h000F);
			do_op(OP_OR_MEM);
			bus_acc(CSS_REG_PAIR, 1'b0, 16'h000F, 16'h000F);
		end
		$display("test alu done");
		// table lookup through d and a, then e round trip
		do_op(OP_LOAD_D, 4'h5);
		do_op(OP_LOAD_IMM, 4'hA);
		do_op(OP_TBL, 4'h0, 12'h300);
		do_op(OP_E_FROM_BA);
		do_op(OP_LOAD_IMM, 4'h0);
		do_op(OP_BA_FROM_E);
		bus_acc(CSS_REG_PAIR, 1'b0, {2{8'h5A ^ 8'h17}}, 16'hFFFF);
		bus_acc(CSS_REG_STAT, 1'b0, 16'h00E0, 16'h00E8);
		$display("test lookup done");
		// port pin low under y gives a skip of the next op
		do_op(OP_LOAD_DP, 4'h0, 12'h003);
		port_d_in <= 8'($urandom) & 8'hF7;
		do_op(OP_PBIT_SKIP);
		do_op(OP_LOAD_IMM, 4'h7);
		bus_acc(CSS_REG_PAIR, 1'b0, 16'h000D, 16'h000F);
		// port latch bit under y, then a cleared ram bit skips the next op
		exp_q.push_back({16'h00FF, 16'h0008});
		do_op(OP_PBIT_SET);
		exp_q.push_back({16'h00FF, 16'h0000});
		do_op(OP_PBIT_CLR);
		do_op(OP_LOAD_DP, 4'h0, 12'h035);
		do_op(OP_MBIT_CLR, 4'h0, 12'h000, 2'h1);
		do_op(OP_MBIT_SKIP, 4'h0, 12'h000, 2'h1);
		do_op(OP_LOAD_IMM, 4'h2);
		do_op(OP_AND_MEM);
		bus_acc(CSS_REG_PAIR, 1'b0, 16'h000D, 16'h000F);
		$display("test skip done");
		// stack pointer from reset, nine calls wrap it
		do_op(OP_P2_CALL, 4'h0, 12'h100);
		bus_acc(CSS_REG_STAT, 1'b0, 16'h0000, 16'h00E0);
		bus_acc(CSS_REG_PC, 1'b0, 16'h0100, 16'hFFFF);
		repeat (8) do_op(OP_CALL, 4'h0, 12'h100);
		bus_acc(CSS_REG_STAT, 1'b0, 16'h0000, 16'h00E0);
		do_op(OP_RET);
		do_op(OP_SP_TO_ACC);
		bus_acc(CSS_REG_PAIR, 1'b0, 16'h0007, 16'h000F);
		// page-two call through d and a, then back so the stack is level
		do_op(OP_LOAD_D, 4'h3);
		do_op(OP_P2_CALL_ACC);
		bus_acc(CSS_REG_PC, 1'b0, 16'h0137, 16'hFFFF);
		do_op(OP_RET);
		$display("test stack done");
		// interrupt: bit 2 requested but not enabled, bit 3 taken
		do_op(OP_SET_CY);
		do_op(OP_LOAD_IMM, 4'h6);
		irq_en <= 8'h08;
		irq_req <= 8'h0C;
		exp_q.push_back({16'h00FF, 16'h0008});
		bus_acc(CSS_REG_CTRL, 1'b1, 16'h0001, 16'hFFFF);
		for (n = 0; n < 10 && irq_ack === 8'h00; n++)
			@(posedge clk);
		irq_req <= 8'h04;
		bus_acc(CSS_REG_PC, 1'b0, 16'h0086, 16'hFFFF);
		bus_acc(CSS_REG_STAT, 1'b0, 16'h0000, 16'h00E1);
		do_op(OP_LOAD_IMM, 4'h0);
		do_op(OP_CLR_CY);
		do_op(OP_RET_IRQ);
		bus_acc(CSS_REG_PAIR, 1'b0, 16'h0006, 16'h000F);
		bus_acc(CSS_REG_STAT, 1'b0, 16'h0002, 16'h0002);
		$display("test interrupt done");
		// enable lands one op late, disable at once; no request is pending here
		do_op(OP_EI);
		bus_acc(CSS_REG_STAT, 1'b0, 16'h0010, 16'h0011);
		do_op(OP_NOP);
		bus_acc(CSS_REG_STAT, 1'b0, 16'h0001, 16'h0011);
		do_op(OP_DI);
		bus_acc(CSS_REG_STAT, 1'b0, 16'h0000, 16'h0011);
		// jump through d and a inside the target's page
		do_op(OP_JUMP_ACC, 4'h0, 12'h300);
		bus_acc(CSS_REG_PC, 1'b0, 16'h0336, 16'hFFFF);
		// last offset of a page rolls into the next page
		do_op(OP_JUMP, 4'h0, 12'h07F);
		do_op(OP_NOP);
		bus_acc(CSS_REG_PC, 1'b0, 16'h0080, 16'hFFFF);
		do_op(OP_NOP, 4'h0, 12'h000, 2'h0, 1'b1);
		bus_acc(CSS_REG_PC, 1'b0, 16'h0082, 16'hFFFF);
		$display("test page done");
		repeat (3) @(posedge clk);
		end_of_test();
	end
endmodule
`default_nettype wire

/* File: tb/css_rom_model.sv */
// behavioural program rom on the far side of the core's lookup port
`default_nettype none
module css_rom_model (
	input wire logic [11:0] rom_addr,
	input wire logic rom_rd,
	output logic [9:0] rom_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] word;
	// ten-bit word at every address of every 128-word page, low byte doubles as table data
	assign word = {rom_addr[9:8], rom_addr[7:0] ^ 8'h17};
	// outside a read the lines show the inverse, so stale data never passes for valid
	assign rom_data = rom_rd ? word : ~word;
endmodule
`default_nettype wire
